// ===== logic/wdt1_consts.vh
// constants for the second watchdog / interval timer channel
`ifndef WDT1_CONSTS_VH
`define WDT1_CONSTS_VH
// write keys carried in the high byte of a word write
`define KEY_COUNTER 8'h5A
`define KEY_CONTROL 8'hA5
// control/status field positions
`define BIT_OVERFLOW 7
`define BIT_MODE 6
`define BIT_RUN 5
`define BIT_PRESCALER 4
`define BIT_ACTION 3
`define CKS_HI 2
`define CKS_LO 0
// reset values and counter maximum
`define CONTROL_RESET 8'h00
`define COUNTER_RESET 8'h00
`define COUNTER_MAX 8'hFF
// watchdog reset pulse lengths in system clocks
`define INTERNAL_RESET_CLOCKS 10'h206
`define RESET_PIN_CLOCKS 10'h084
`endif

// ===== logic/watchdog_channel_one_control.v
// control, counter and overflow logic of the second watchdog / interval timer channel
//
// Notes on behaviour
// - counter wrap FF to 00 sets overflow flag
// - watchdog internal reset clears the overflow flag
// - flag clears by zero write after read
// - writing run enable zero clears the flag
// - writing one to the flag does nothing
// - mode bit six: interval zero, watchdog one
// - run enable one starts counting selected clock
// - run enable zero stops, zeroes the counter
// - bit four picks system or sub prescaler
// - action bit three: interrupt zero, reset one
// - system prescaler code 000 divides by two
// - sub prescaler code 111 divides by 256
// - eight bit readable writable up counter
// - keyed word writes: 5A counter, A5 control
// - reset 518 clocks, pin low 132 clocks
// - interval interrupt rises with overflow flag
`timescale 1ns/1ns
`include "wdt1_consts.vh"

module watchdog_channel_one_control (
  input wire clock,
  input wire srst,
  input wire write_strobe,
  input wire [15:0] write_word,
  input wire read_strobe,
  input wire read_select_counter,
  input wire sub_clock_in,
  output reg [7:0] read_data,
  output wire interval_overflow_interrupt,
  output reg nmi_request,
  output reg internal_reset_request,
  output reg reset_output_pin_n
);

  // control/status fields
  reg overflow_flag; // sticky overflow
  reg timer_mode_select; // 0 interval, 1 watchdog
  reg timer_run_enable; // counter runs while set
  reg prescaler_source_select; // 0 system, 1 sub-clock
  reg overflow_action; // 0 nmi, 1 internal reset
  reg [2:0] clock_divider_select; // tap code
  reg [7:0] watchdog_counter; // the up counter
  reg clear_armed; // flag was read as one
  reg [16:0] system_clock_prescaler; // free running on clock
  reg [7:0] sub_clock_prescaler; // advanced on sub-clock edges
  reg sub_sync_a; // synchroniser first stage
  reg sub_sync_b; // synchroniser second stage
  reg sub_sync_c; // delayed copy for edge detect
  reg [9:0] internal_reset_count; // remaining internal reset clocks
  reg [9:0] pin_count; // remaining pin low clocks

  wire [7:0] control_value;
  wire counter_write;
  wire control_write;
  wire sub_edge;
  wire count_tick;
  wire overflow_event;
  wire internal_reset_active;

  // system prescaler tap: a tick every 2^(k+1) clocks when low k+1 bits are ones
  function system_tap_hit;
    input [16:0] cnt;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: system_tap_hit = &cnt[0:0]; // divide by 2
        3'h1: system_tap_hit = &cnt[5:0]; // divide by 64
        3'h2: system_tap_hit = &cnt[6:0]; // divide by 128
        3'h3: system_tap_hit = &cnt[8:0]; // divide by 512
        3'h4: system_tap_hit = &cnt[10:0]; // divide by 2048
        3'h5: system_tap_hit = &cnt[12:0]; // divide by 8192
        3'h6: system_tap_hit = &cnt[14:0]; // divide by 32768
        default: system_tap_hit = &cnt[16:0]; // divide by 131072
      endcase
    end
  endfunction

  // sub prescaler tap: divide by 2^(sel+1), monotonic over the codes
  function sub_tap_hit;
    input [7:0] cnt;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: sub_tap_hit = &cnt[0:0];
        3'h1: sub_tap_hit = &cnt[1:0];
        3'h2: sub_tap_hit = &cnt[2:0];
        3'h3: sub_tap_hit = &cnt[3:0];
        3'h4: sub_tap_hit = &cnt[4:0];
        3'h5: sub_tap_hit = &cnt[5:0];
        3'h6: sub_tap_hit = &cnt[6:0];
        default: sub_tap_hit = &cnt[7:0]; // divide by 256
      endcase
    end
  endfunction

  // keyed decode of the shared write address
  assign counter_write = write_strobe && (write_word[15:8] == `KEY_COUNTER);
  assign control_write = write_strobe && (write_word[15:8] == `KEY_CONTROL);

  assign control_value = {overflow_flag, timer_mode_select, timer_run_enable,
                          prescaler_source_select, overflow_action, clock_divider_select};

  assign sub_edge = sub_sync_b && !sub_sync_c;
  assign internal_reset_active = internal_reset_request;

  // counting clock chosen by prescaler source
  assign count_tick = prescaler_source_select ?
                      (sub_edge && sub_tap_hit(sub_clock_prescaler, clock_divider_select)) :
                      system_tap_hit(system_clock_prescaler, clock_divider_select);

  // a counter write in the same cycle wins over the increment
  assign overflow_event = timer_run_enable && count_tick && !counter_write &&
                          (watchdog_counter == `COUNTER_MAX);

  // interrupt follows the flag, so it rises in the cycle the flag shows set
  assign interval_overflow_interrupt = overflow_flag && !timer_mode_select;

  // sub-clock pin synchroniser and edge detect
  always @(posedge clock) begin
    if (srst) begin
      sub_sync_a <= 1'b0;
      sub_sync_b <= 1'b0;
      sub_sync_c <= 1'b0;
    end else begin
      sub_sync_a <= sub_clock_in;
      sub_sync_b <= sub_sync_a;
      sub_sync_c <= sub_sync_b;
    end
  end

  // prescalers run freely so that a tap change takes effect at once
  always @(posedge clock) begin
    if (srst) begin
      system_clock_prescaler <= 17'h0_0000;
      sub_clock_prescaler <= 8'h00;
    end else begin
      system_clock_prescaler <= system_clock_prescaler + 17'h0_0001;
      if (sub_edge) begin
        sub_clock_prescaler <= sub_clock_prescaler + 8'h01;
      end
    end
  end

  // control fields; the watchdog internal reset restores them like a chip reset
  always @(posedge clock) begin
    if (srst || internal_reset_active) begin
      timer_mode_select <= 1'b0;
      timer_run_enable <= 1'b0;
      prescaler_source_select <= 1'b0;
      overflow_action <= 1'b0;
      clock_divider_select <= 3'h0;
    end else if (control_write) begin
      timer_mode_select <= write_word[`BIT_MODE];
      timer_run_enable <= write_word[`BIT_RUN];
      prescaler_source_select <= write_word[`BIT_PRESCALER];
      overflow_action <= write_word[`BIT_ACTION];
      clock_divider_select <= write_word[`CKS_HI:`CKS_LO];
    end
  end

  // the counter
  always @(posedge clock) begin
    if (srst || internal_reset_active) begin
      watchdog_counter <= `COUNTER_RESET;
    end else if (!timer_run_enable || (control_write && !write_word[`BIT_RUN])) begin
      watchdog_counter <= `COUNTER_RESET;
    end else if (counter_write) begin
      watchdog_counter <= write_word[7:0];
    end else if (count_tick) begin
      watchdog_counter <= watchdog_counter + 8'h01;
    end
  end

  // overflow flag: a new overflow wins over any clear in the same cycle
  always @(posedge clock) begin
    if (srst || internal_reset_active) begin
      overflow_flag <= 1'b0;
      clear_armed <= 1'b0;
    end else if (overflow_event) begin
      overflow_flag <= 1'b1;
      clear_armed <= 1'b0;
    end else if (control_write && !write_word[`BIT_RUN]) begin
      overflow_flag <= 1'b0;
      clear_armed <= 1'b0;
    end else if (control_write && !write_word[`BIT_OVERFLOW] && clear_armed) begin
      overflow_flag <= 1'b0;
      clear_armed <= 1'b0;
    end else if (read_strobe && !read_select_counter && overflow_flag) begin
      clear_armed <= 1'b1;
    end
    // a one written to the flag is simply not stored
  end

  // overflow actions and the watchdog reset pulses
  always @(posedge clock) begin
    if (srst) begin
      nmi_request <= 1'b0;
      internal_reset_request <= 1'b0;
      reset_output_pin_n <= 1'b1;
      internal_reset_count <= 10'd0;
      pin_count <= 10'd0;
    end else begin
      nmi_request <= overflow_event && timer_mode_select && !overflow_action;
      if (overflow_event && timer_mode_select && overflow_action) begin
        internal_reset_request <= 1'b1;
        reset_output_pin_n <= 1'b0;
        internal_reset_count <= `INTERNAL_RESET_CLOCKS - 10'd1;
        pin_count <= `RESET_PIN_CLOCKS - 10'd1;
      end else begin
        // the two lengths run side by side from the same start
        if (internal_reset_count != 10'd0) begin
          internal_reset_count <= internal_reset_count - 10'd1;
        end else begin
          internal_reset_request <= 1'b0;
        end
        if (pin_count != 10'd0) begin
          pin_count <= pin_count - 10'd1;
        end else begin
          reset_output_pin_n <= 1'b1;
        end
      end
    end
  end

  // registered read port; control/status reserved bits do not exist here
  always @(posedge clock) begin
    if (srst) begin
      read_data <= 8'h00;
    end else if (read_strobe) begin
      read_data <= read_select_counter ? watchdog_counter : control_value;
    end
  end

endmodule // watchdog_channel_one_control

// ===== sim/wdt1_monitor.sv
// port checker for the second watchdog / interval timer channel
`timescale 1ns/1ns
module wdt1_monitor (
  input wire clock,
  input wire srst,
  input wire write_strobe,
  input wire read_strobe,
  input wire [7:0] read_data,
  input wire interval_overflow_interrupt,
  input wire nmi_request,
  input wire internal_reset_request,
  input wire reset_output_pin_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // pin low for exactly 132 clocks, internal reset high for exactly 518
  chk_pin_len: assert property (
    $fell(reset_output_pin_n) |-> ##131 !reset_output_pin_n ##1 reset_output_pin_n)
    else $error("reset pin low time wrong");
  chk_int_rst_len: assert property (
    $rose(internal_reset_request) |-> ##[517:517] internal_reset_request ##1 !internal_reset_request)
    else $error("internal reset length wrong");
  chk_reset_pair: assert property (
    $rose(internal_reset_request) |-> $fell(reset_output_pin_n))
    else $error("reset outputs not started together");
  // interrupt action gives a lone pulse and leaves the pin high
  chk_nmi_pulse: assert property (nmi_request |=> !nmi_request)
    else $error("nmi pulse too long");
  chk_nmi_no_pin: assert property (
    nmi_request |-> reset_output_pin_n && !internal_reset_request)
    else $error("nmi with reset outputs");
  // the chip reset must leave every output quiet
  chk_srst_quiet: assert property (disable iff (1'b0) srst |=> read_data == 8'h00 &&
    !interval_overflow_interrupt && !nmi_request && !internal_reset_request && reset_output_pin_n)
    else $error("outputs not idle after reset");
  // only a write can lower the interrupt level
  chk_irq_held: assert property (
    interval_overflow_interrupt && !write_strobe |=> interval_overflow_interrupt)
    else $error("interrupt dropped without a write");
  chk_irq_off_rst: assert property (
    internal_reset_request |-> !interval_overflow_interrupt)
    else $error("interrupt during internal reset");
  chk_rst_read_zero: assert property (
    internal_reset_request && $past(internal_reset_request) && read_strobe |=> read_data == 8'h00)
    else $error("state not cleared by internal reset");
  cover property (nmi_request);
  cover property ($rose(internal_reset_request));
  cover property ($rose(interval_overflow_interrupt));
endmodule // wdt1_monitor
bind watchdog_channel_one_control wdt1_monitor chk (.*);

// ===== sim/watchdog_channel_one_control_tb.sv
// self-checking bench for the second watchdog / interval timer channel
`timescale 1ns/1ns
module watchdog_channel_one_control_tb;
  reg clock = 1'b0;
  reg srst = 1'b1;
  reg write_strobe = 1'b0;
  reg read_strobe = 1'b0;
  reg read_select_counter = 1'b0;
  reg sub_clock_in = 1'b0; // stands still unless a scenario runs it
  reg [15:0] write_word = 16'h0000;
  wire [7:0] read_data;
  wire interval_overflow_interrupt;
  wire nmi_request;
  wire internal_reset_request;
  wire reset_output_pin_n;
  integer n_fail = 0;
  integer checked = 0;
  integer cyc = 0; // free cycle count for period checks
  integer t1;
  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  watchdog_channel_one_control DUT (
    .clock(clock),
    .srst(srst),
    .write_strobe(write_strobe),
    .write_word(write_word),
    .read_strobe(read_strobe),
    .read_select_counter(read_select_counter),
    .sub_clock_in(sub_clock_in),
    .read_data(read_data),
    .interval_overflow_interrupt(interval_overflow_interrupt),
    .nmi_request(nmi_request),
    .internal_reset_request(internal_reset_request),
    .reset_output_pin_n(reset_output_pin_n)
  );
  task conclude;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task check(input [8*10-1:0] what, input [7:0] exp, input [7:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // one keyed word write, strobe held for a single edge
  task wr(input [15:0] w);
    begin
      @(posedge clock);
      write_strobe <= 1'b1;
      write_word <= w;
      @(posedge clock);
      write_strobe <= 1'b0;
    end
  endtask
  // read, then judge the registered result once settled
  task rd(input sel, input [7:0] exp, input [8*10-1:0] what);
    begin
      @(posedge clock);
      read_strobe <= 1'b1;
      read_select_counter <= sel;
      @(posedge clock);
      read_strobe <= 1'b0;
      @(negedge clock);
      check(what, exp, read_data);
    end
  endtask
  // bounded wait: 0 irq, 1 nmi, 2 reset high, 3 reset low
  task await(input integer k, input integer lim);
    integer i;
    begin
      i = 0;
      while (i < lim && !(k == 0 ? interval_overflow_interrupt === 1'b1 : k == 1 ?
          nmi_request === 1'b1 : internal_reset_request === (k == 2))) begin
        @(negedge clock);
        i = i + 1;
      end
      if (i == lim) begin
        check("wait", 8'h01, 8'h00);
        conclude;
      end
    end
  endtask
  task reg_access;
    begin
      rd(0, 8'h00, "ctl rst");
      wr(16'hA587);
      rd(0, 8'h07, "ctl w1");
      wr(16'hA527);
      wr(16'h5A37);
      wr(16'h1200);
      rd(1, 8'h37, "cnt rw");
      wr(16'hA507);
      rd(1, 8'h00, "cnt stop");
    end
  endtask
  task interval_rate;
    begin
      wr(16'hA520);
      wr(16'h5AFE);
      await(0, 10);
      t1 = cyc;
      wr(16'hA520);
      rd(0, 8'hA0, "ovf set");
      rd(0, 8'hA0, "ovf poll");
      wr(16'hA520);
      @(negedge clock);
      check("irq clr", 8'h00, {7'h00, interval_overflow_interrupt});
      await(0, 600);
      check("period", 8'h00, 8'(cyc - t1 - 512));
      check("period hi", 8'h02, 8'((cyc - t1) >> 8));
      wr(16'hA500);
    end
  endtask
  // tap code 1 (divide by 64) must still count and overflow in bounded time
  task tap_order;
    begin
      wr(16'hA521);
      wr(16'h5AFF);
      await(0, 70);
      rd(0, 8'hA1, "tap code1");
      wr(16'hA500);
    end
  endtask
  task watchdog_nmi;
    begin
      wr(16'hA560);
      wr(16'h5AFF);
      await(1, 10);
      check("irq wd", 8'h00, {7'h00, interval_overflow_interrupt});
      rd(0, 8'hE0, "wd flag");
      wr(16'hA540);
      rd(0, 8'h40, "tme clr");
    end
  endtask
  task watchdog_reset;
    begin
      wr(16'hA568);
      wr(16'h5AFF);
      await(2, 10);
      check("pin", 8'h00, {7'h00, reset_output_pin_n});
      rd(0, 8'h00, "ctl in rst");
      await(3, 600);
      rd(0, 8'h00, "auto clr");
    end
  endtask
  task sub_prescaler;
    begin
      wr(16'hA530);
      wr(16'h5AFF);
      repeat (20) @(posedge clock);
      rd(0, 8'h30, "pss idle");
      wr(16'hA537);
      repeat (520) @(posedge clock) sub_clock_in <= ~sub_clock_in;
      rd(0, 8'hB7, "sub 256");
    end
  endtask
  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    reg_access;
    interval_rate;
    tap_order;
    watchdog_nmi;
    watchdog_reset;
    sub_prescaler;
    conclude;
  end
endmodule // watchdog_channel_one_control_tb
